// *** rtl/pulse_generator.sv ***
// Three-channel digital pulse generator with register port and line drive
//
// Notes on behaviour
// R1: Generator outputs drive multipurpose lines zero, one and two.
// R2: Tick derives from sampling clock; resulting tick rate is readable.
// R3: Tick rate never exceeds 156.25 MS/s, one tick per 6.4 ns.
// R4: Modes: single shot, repetition per trigger, gated while gate active.
// R5: Trigger source: software, card trigger, another generator, input lines.
// R6: Optional trigger qualifier: none, armed state or running state.
// R7: Period length is 32-bit, in ticks, at least 2.
// R8: High width is 32-bit, in ticks, at least 1.
// R9: Start delay is 32-bit, in ticks, from 0 upward.
// R10: Loop count is 32-bit; zero repeats without end.
// R11: Line outputs update at the sampling clock rate.
// R12: Output high for width ticks, low for rest of period.
// R13: After a trigger, wait delay ticks, then run the loops.
//
// Our own choices: the strobed register port and the register addresses.
`default_nettype none
module pulse_generator
  import pulse_gen_pkg::*;
#(
  parameter int unsigned CLOCK_HZ = SAMPLE_HZ
)(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              card_trig,
  input  wire logic              armed_state,
  input  wire logic              running_state,
  input  wire logic [2:0]        multipurpose_io_lines_in,
  output logic      [2:0]        multipurpose_io_lines_out,
  output logic      [2:0]        multipurpose_io_lines_oe
);

  pulse_ctrl_t   ctrl   [NUM_GEN];
  pulse_timing_t timing [NUM_GEN];
  logic [3:0]    tick_shift;
  logic [3:0]    shift_eff;
  logic [15:0]   tick_cnt;
  logic [15:0]   tick_mask;
  logic          tick;
  logic [31:0]   tick_rate;
  logic [2:0]    sw_trig;
  logic [2:0]    line_meta;
  logic [2:0]    line_sync;
  logic [2:0]    gen_pulse;
  logic [2:0]    gen_active;
  logic [2:0]    gen_done;
  logic [7:0]    src_prev [NUM_GEN];
  logic [7:0]    src_lvl  [NUM_GEN];
  logic [1:0]    gen_sel;
  logic [4:0]    reg_ofs;
  logic          gen_hit;
  logic [31:0]   next_rdata;

  assign gen_sel = reg_addr[6:5];
  assign reg_ofs = reg_addr[4:0];
  assign gen_hit = (reg_addr[7] == 1'b0) && (gen_sel < 2'(NUM_GEN));

  // R2 R3 tick divider, fastest allowed rate clamped from above
  assign shift_eff = (tick_shift < MIN_SHIFT) ? MIN_SHIFT : tick_shift;
  assign tick_mask = 16'((17'h1_0000 >> (5'h10 - {1'b0, shift_eff})) - 17'h1);
  assign tick      = (tick_cnt == 16'h0000);
  assign tick_rate = CLOCK_HZ >> shift_eff;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
    end else if (tick_cnt >= tick_mask) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // Lines come from outside the clock domain
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_meta <= 3'h0;
      line_sync <= 3'h0;
    end else begin
      line_meta <= multipurpose_io_lines_in;
      line_sync <= line_meta;
    end
  end

  // Register writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_GEN; i++) begin
        ctrl[i]          <= '{GATE_NONE, SRC_SOFTWARE, MODE_SINGLE, 1'b0};
        timing[i].length <= RST_LENGTH;
        timing[i].width  <= RST_WIDTH;
        timing[i].delay  <= RST_DELAY;
        timing[i].loops  <= RST_LOOPS;
      end
      tick_shift <= MIN_SHIFT;
    end else if (reg_wr) begin
      if (gen_hit) begin
        case (reg_ofs)
          OFS_LENGTH: timing[gen_sel].length <= reg_wdata;
          OFS_WIDTH:  timing[gen_sel].width  <= reg_wdata;
          OFS_DELAY:  timing[gen_sel].delay  <= reg_wdata;
          OFS_LOOPS:  timing[gen_sel].loops  <= reg_wdata;
          OFS_CTRL: begin
            ctrl[gen_sel].enable <= reg_wdata[CTRL_EN_BIT];
            ctrl[gen_sel].mode   <=
              run_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
            ctrl[gen_sel].src    <=
              trig_src_t'(reg_wdata[CTRL_SRC_LSB +: 3]);
            ctrl[gen_sel].gate   <=
              gate_sel_t'(reg_wdata[CTRL_GATE_LSB +: 2]);
          end
          default: ;
        endcase
      end else if (reg_addr == ADDR_TICK_SHIFT) begin
        tick_shift <= reg_wdata[3:0];
      end
    end
  end

  // Software trigger is a one-cycle pulse per written bit
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_trig <= 3'h0;
    end else begin
      sw_trig <= (reg_wr && reg_addr == ADDR_CMD) ? reg_wdata[2:0] : 3'h0;
    end
  end

  // Register reads, unmapped addresses return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (gen_hit) begin
      case (reg_ofs)
        OFS_LENGTH: next_rdata = timing[gen_sel].length;
        OFS_WIDTH:  next_rdata = timing[gen_sel].width;
        OFS_DELAY:  next_rdata = timing[gen_sel].delay;
        OFS_LOOPS:  next_rdata = timing[gen_sel].loops;
        OFS_CTRL:   next_rdata = {24'h00_0000, ctrl[gen_sel]};
        OFS_STATUS: next_rdata = {29'h0000_0000, gen_done[gen_sel],
                                  gen_active[gen_sel], gen_pulse[gen_sel]};
        default:    next_rdata = 32'h0000_0000;
      endcase
    end else if (reg_addr == ADDR_TICK_SHIFT) begin
      next_rdata = {28'h000_0000, shift_eff};
    end else if (reg_addr == ADDR_TICK_RATE) begin
      // R2 tick rate readable
      next_rdata = tick_rate;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_ch
    logic qual;
    logic sel_lvl;
    logic sel_rise;

    // R5 trigger source vector, indexed by source code
    assign src_lvl[g] = {line_sync[2], line_sync[1], line_sync[0],
                         gen_pulse[2], gen_pulse[1], gen_pulse[0],
                         card_trig, sw_trig[g]};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        src_prev[g] <= 8'h00;
      end else begin
        src_prev[g] <= src_lvl[g];
      end
    end

    // R6 gate qualifier
    always_comb begin
      case (ctrl[g].gate)
        GATE_NONE:    qual = 1'b1;
        GATE_ARMED:   qual = armed_state;
        GATE_RUNNING: qual = running_state;
        default:      qual = 1'b0;
      endcase
    end

    assign sel_lvl  = src_lvl[g][ctrl[g].src] && qual;
    assign sel_rise = src_lvl[g][ctrl[g].src] &&
                      !src_prev[g][ctrl[g].src] && qual;

    pulse_channel u_chan (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .tick      (tick),
      .ctrl      (ctrl[g]),
      .timing    (timing[g]),
      .trig_evt  (sel_rise),
      .gate_lvl  (sel_lvl),
      .pulse_out (gen_pulse[g]),
      .active    (gen_active[g]),
      .done      (gen_done[g])
    );

    // R1 R11 line drive refreshed every sampling clock
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        multipurpose_io_lines_out[g] <= 1'b0;
        multipurpose_io_lines_oe[g]  <= 1'b0;
      end else begin
        multipurpose_io_lines_out[g] <= gen_pulse[g];
        multipurpose_io_lines_oe[g]  <= ctrl[g].enable;
      end
    end

    AST_LINE_FOLLOWS: assert property (  // R11
      @(posedge ref_clk) disable iff (sys_rst)
      ##1 multipurpose_io_lines_out[g] == $past(gen_pulse[g]))
      else $error("Line output lags generator");

    AST_GATE_BLOCKS: assert property (  // R6
      @(posedge ref_clk) disable iff (sys_rst)
      (ctrl[g].gate == GATE_ARMED && !armed_state) |-> !sel_rise)
      else $error("Trigger passed a closed gate");

    AST_RUN_GATE_BLOCKS: assert property (  // R6
      @(posedge ref_clk) disable iff (sys_rst)
      (ctrl[g].gate == GATE_RUNNING && !running_state) |-> !sel_rise)
      else $error("Trigger passed a closed run gate");

    AST_OE_FOLLOWS: assert property (  // R1
      @(posedge ref_clk) disable iff (sys_rst)
      ##1 multipurpose_io_lines_oe[g] == $past(ctrl[g].enable))
      else $error("Line enable does not follow generator enable");

    // Disabling must abort a run at once, not finish the period
    AST_DISABLE_STOPS: assert property (  // R4
      @(posedge ref_clk) disable iff (sys_rst)
      !ctrl[g].enable |=> !gen_active[g] && !gen_done[g])
      else $error("Disabled generator still busy");

    AST_OFF_LOW: assert property (  // R12
      @(posedge ref_clk) disable iff (sys_rst)
      !ctrl[g].enable |-> ##2 !gen_pulse[g])
      else $error("Disabled generator still pulsing");

    AST_GATED_DROP: assert property (  // R4
      @(posedge ref_clk) disable iff (sys_rst)
      (ctrl[g].mode == MODE_GATED && !sel_lvl) |=> !gen_active[g])
      else $error("Gated generator ran with gate closed");
  end

  sequence s_rate_read;
    reg_rd && reg_addr == ADDR_TICK_RATE;
  endsequence

  AST_RATE_READ: assert property (  // R2
    @(posedge ref_clk) disable iff (sys_rst)
    s_rate_read ##1 1'b1 |-> reg_rdata == $past(tick_rate))
    else $error("Tick rate readback wrong");

  AST_RATE_LIMIT: assert property (  // R3
    @(posedge ref_clk) disable iff (sys_rst)
    tick_rate <= TICK_MAX_HZ)
    else $error("Tick rate above limit");

  AST_TICK_SPACING: assert property (  // R2
    @(posedge ref_clk) disable iff (sys_rst)
    (tick && shift_eff != 4'h0 && !$changed(shift_eff)) |=> !tick)
    else $error("Ticks too close for divider");

  AST_SHIFT_FLOOR: assert property (  // R3
    @(posedge ref_clk) disable iff (sys_rst)
    shift_eff >= MIN_SHIFT)
    else $error("Tick divider below its floor");

  // A write to the command word must fire exactly the bits written
  sequence s_cmd_write;
    reg_wr && reg_addr == ADDR_CMD;
  endsequence

  AST_SW_TRIG: assert property (  // R5
    @(posedge ref_clk) disable iff (sys_rst)
    s_cmd_write |=> sw_trig == $past(reg_wdata[2:0]))
    else $error("Software trigger bits not issued");

  // Read data fall back to zero so a stale word is never taken
  AST_RDATA_IDLE: assert property (  // R2
    @(posedge ref_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("Read data stood beyond their cycle");

  AST_LINE_SYNC: assert property (  // R5
    @(posedge ref_clk) disable iff (sys_rst)
    ##2 line_sync == $past(multipurpose_io_lines_in, 2))
    else $error("Line input not passed through two stages");

endmodule
`default_nettype wire

// *** rtl/pulse_gen_pkg.sv ***
// Shared constants and types for the digital pulse generator
`default_nettype none
package pulse_gen_pkg;

  localparam int unsigned NUM_GEN        = 3;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;

  // Sampling clock and tick limits
  localparam int unsigned SAMPLE_HZ      = 100_000_000;
  localparam int unsigned CLK_PERIOD_PS  = 10_000;
  localparam int unsigned TICK_MAX_HZ    = 156_250_000;
  localparam int unsigned TICK_MIN_PS    = 6_400;
  localparam int unsigned TICK_MIN_CYC_R =
    (TICK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TICK_MIN_CYC   =
    (TICK_MIN_CYC_R < 1) ? 1 : TICK_MIN_CYC_R;
  localparam logic [3:0]  MIN_SHIFT      = 4'($clog2(TICK_MIN_CYC));
  localparam logic [3:0]  MAX_SHIFT      = 4'hF;

  // Per-generator register block, base = index * GEN_STRIDE
  localparam logic [7:0] GEN_STRIDE      = 8'h20;
  localparam logic [4:0] OFS_LENGTH      = 5'h00;
  localparam logic [4:0] OFS_WIDTH       = 5'h04;
  localparam logic [4:0] OFS_DELAY       = 5'h08;
  localparam logic [4:0] OFS_LOOPS       = 5'h0C;
  localparam logic [4:0] OFS_CTRL        = 5'h10;
  localparam logic [4:0] OFS_STATUS      = 5'h14;

  // Global registers
  localparam logic [7:0] ADDR_CMD        = 8'h60;
  localparam logic [7:0] ADDR_TICK_SHIFT = 8'h64;
  localparam logic [7:0] ADDR_TICK_RATE  = 8'h68;

  // Reset values and limits
  localparam logic [31:0] RST_LENGTH     = 32'h0000_0002;
  localparam logic [31:0] RST_WIDTH      = 32'h0000_0001;
  localparam logic [31:0] RST_DELAY      = 32'h0000_0000;
  localparam logic [31:0] RST_LOOPS      = 32'h0000_0000;
  localparam logic [31:0] MIN_LENGTH     = 32'h0000_0002;
  localparam logic [31:0] MIN_WIDTH      = 32'h0000_0001;

  // Control field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MODE_LSB  = 1;
  localparam int unsigned CTRL_SRC_LSB   = 3;
  localparam int unsigned CTRL_GATE_LSB  = 6;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_GATED  = 2'b10
  } run_mode_t;

  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'b000,
    SRC_CARD     = 3'b001,
    SRC_GEN0     = 3'b010,
    SRC_GEN1     = 3'b011,
    SRC_GEN2     = 3'b100,
    SRC_LINE0    = 3'b101,
    SRC_LINE1    = 3'b110,
    SRC_LINE2    = 3'b111
  } trig_src_t;

  typedef enum logic [1:0] {
    GATE_NONE    = 2'b00,
    GATE_ARMED   = 2'b01,
    GATE_RUNNING = 2'b10
  } gate_sel_t;

  typedef struct packed {
    gate_sel_t gate;
    trig_src_t src;
    run_mode_t mode;
    logic      enable;
  } pulse_ctrl_t;

  typedef struct packed {
    logic [31:0] length;
    logic [31:0] width;
    logic [31:0] delay;
    logic [31:0] loops;
  } pulse_timing_t;

endpackage
`default_nettype wire

// *** rtl/pulse_channel.sv ***
// One pulse generator channel: delay, period, width and loop sequencing
`default_nettype none
module pulse_channel
  import pulse_gen_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          tick,
  input  wire pulse_ctrl_t   ctrl,
  input  wire pulse_timing_t timing,
  input  wire logic          trig_evt,
  input  wire logic          gate_lvl,
  output logic               pulse_out,
  output logic               active,
  output logic               done
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10,
    ST_DONE  = 2'b11
  } chan_state_t;

  chan_state_t state;
  logic [31:0] cnt;
  logic [31:0] loop_cnt;
  logic [31:0] len_eff;
  logic [31:0] wid_eff;
  logic        gated;
  logic        start;
  logic        last_tick;

  // R7 R8 minimum length and width
  assign len_eff = (timing.length < MIN_LENGTH) ? MIN_LENGTH : timing.length;
  assign wid_eff = (timing.width < MIN_WIDTH) ? MIN_WIDTH : timing.width;

  assign gated     = (ctrl.mode == MODE_GATED);
  // R4 gated start follows the level, others an edge
  assign start     = gated ? gate_lvl : trig_evt;
  assign last_tick = (cnt == len_eff - 32'h0000_0001);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= ST_IDLE;
      cnt      <= 32'h0000_0000;
      loop_cnt <= 32'h0000_0000;
    end else if (!ctrl.enable) begin
      state    <= ST_IDLE;
      cnt      <= 32'h0000_0000;
      loop_cnt <= 32'h0000_0000;
    end else begin
      case (state)
        // R13 delay first, zero delay runs at once
        ST_IDLE: begin
          if (start) begin
            cnt      <= 32'h0000_0000;
            loop_cnt <= 32'h0000_0000;
            state    <= (timing.delay == 32'h0000_0000) ? ST_RUN : ST_DELAY;
          end
        end
        // R9 delay counted in ticks
        ST_DELAY: begin
          if (gated && !gate_lvl) begin
            state <= ST_IDLE;
          end else if (tick) begin
            if (cnt == timing.delay - 32'h0000_0001) begin
              cnt   <= 32'h0000_0000;
              state <= ST_RUN;
            end else begin
              cnt <= cnt + 32'h0000_0001;
            end
          end
        end
        // R10 loop count, zero repeats forever
        ST_RUN: begin
          if (gated && !gate_lvl) begin
            state <= ST_IDLE;
          end else if (tick) begin
            if (last_tick) begin
              cnt <= 32'h0000_0000;
              if (timing.loops != 32'h0000_0000 &&
                  loop_cnt == timing.loops - 32'h0000_0001) begin
                state <= (ctrl.mode == MODE_SINGLE) ? ST_DONE : ST_IDLE;
              end else begin
                loop_cnt <= loop_cnt + 32'h0000_0001;
              end
            end else begin
              cnt <= cnt + 32'h0000_0001;
            end
          end
        end
        // Single shot holds here until the channel is disabled
        ST_DONE: state <= ST_DONE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // R12 high for width ticks, low for the rest
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (state == ST_RUN) && (cnt < wid_eff);
    end
  end

  assign active = (state == ST_DELAY) || (state == ST_RUN);
  assign done   = (state == ST_DONE);

  AST_IDLE_LOW: assert property (  // R12
    @(posedge ref_clk) disable iff (sys_rst)
    (state == ST_IDLE || state == ST_DONE) |=> !pulse_out)
    else $error("Pulse output high outside a period");

  AST_DELAY_LOW: assert property (  // R13
    @(posedge ref_clk) disable iff (sys_rst)
    (state == ST_DELAY) |=> !pulse_out)
    else $error("Pulse output high during start delay");

  AST_WIDTH_HIGH: assert property (  // R8
    @(posedge ref_clk) disable iff (sys_rst)
    (state == ST_RUN && cnt == 32'h0000_0000) |=> pulse_out)
    else $error("Period did not begin high");

  AST_INFINITE: assert property (  // R10
    @(posedge ref_clk) disable iff (sys_rst)
    (state == ST_RUN && ctrl.enable && ctrl.mode != MODE_GATED &&
     timing.loops == 32'h0000_0000) |=> (state == ST_RUN))
    else $error("Infinite loop count left run state");

endmodule
`default_nettype wire

// *** sim/line_partner.sv ***
// Equipment on the three multipurpose lines: drives inputs, times pulses
`default_nettype none
module line_partner (
  input  wire logic       ref_clk,
  input  wire logic       clr,
  input  wire logic [2:0] drive,
  input  wire logic [2:0] lines_out,
  input  wire logic [2:0] lines_oe,
  output logic      [2:0] lines_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] since;
  logic [2:0]  prev;
  logic [2:0]  seen;
  logic [31:0] rises [3];
  logic [31:0] hi_len [3];
  logic [31:0] lo_len [3];
  logic [31:0] first_rise [3];
  logic [31:0] run [3];
  // A line that the block drives reads back its own level
  assign lines_in = (lines_out & lines_oe) | (drive & ~lines_oe);
  // A line counts only while its driver is enabled
  assign seen = lines_out & lines_oe;
  always @(posedge ref_clk) begin
    since <= clr ? 32'h0 : since + 32'h1;
    prev <= seen;
    for (int g = 0; g < 3; g++) begin
      if (clr) begin
        rises[g] <= 32'h0;
        run[g] <= 32'h0;
        hi_len[g] <= 32'h0;
        lo_len[g] <= 32'h0;
        first_rise[g] <= 32'h0;
      end else if (seen[g] && !prev[g]) begin
        rises[g] <= rises[g] + 32'h1;
        lo_len[g] <= run[g];
        run[g] <= 32'h1;
        if (rises[g] == 32'h0) begin
          first_rise[g] <= since;
        end
      end else if (!seen[g] && prev[g]) begin
        hi_len[g] <= run[g];
        run[g] <= 32'h1;
      end else begin
        run[g] <= run[g] + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/test_pulse_generator.sv ***
// Self-checking bench for the three-channel pulse generator
`default_nettype none
module test_pulse_generator import pulse_gen_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 1'h0;
  logic              sys_rst = 1'h1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic              reg_wr = 1'h0;
  logic              reg_rd = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic              card_trig = 1'h0;
  logic              armed_state = 1'h0;
  logic              running_state = 1'h0;
  logic [2:0]        lines_in;
  logic [2:0]        lines_out;
  logic [2:0]        lines_oe;
  logic [2:0]        drive = 3'h0;
  logic              clr = 1'h1;
  logic [31:0]       t0;
  int                err_count = 0;
  int                checked = 0;
  int                cycles = 0;

  always #5 ref_clk = ~ref_clk;

  pulse_generator #(.CLOCK_HZ(SAMPLE_HZ)) pulse_generator_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .card_trig(card_trig),
    .armed_state(armed_state), .running_state(running_state),
    .multipurpose_io_lines_in(lines_in),
    .multipurpose_io_lines_out(lines_out),
    .multipurpose_io_lines_oe(lines_oe)
  );

  line_partner line_partner_inst (
    .ref_clk(ref_clk), .clr(clr), .drive(drive),
    .lines_out(lines_out), .lines_oe(lines_oe), .lines_in(lines_in)
  );

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard: all scenarios fit well inside this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    check(n, e, reg_rdata);
  endtask

  function automatic logic [31:0] cw(run_mode_t m, trig_src_t s,
                                     gate_sel_t gt);
    pulse_ctrl_t c;
    c = '{gate: gt, src: s, mode: m, enable: 1'h1};
    return {24'h0, c};
  endfunction

  // Disable first so the write also rearms a finished single shot
  task automatic setup(input int g, input logic [31:0] l, w, dl, lp, c);
    logic [7:0] b;
    b = 8'(g) * GEN_STRIDE;
    wr(b + 8'(OFS_CTRL), 32'h0);
    wr(b + 8'(OFS_LENGTH), l);
    wr(b + 8'(OFS_WIDTH), w);
    wr(b + 8'(OFS_DELAY), dl);
    wr(b + 8'(OFS_LOOPS), lp);
    wr(b + 8'(OFS_CTRL), c);
  endtask

  task automatic mon_clr;
    @(posedge ref_clk);
    clr <= 1'h1;
    @(posedge ref_clk);
    clr <= 1'h0;
  endtask

  task automatic fire(input logic [2:0] m);
    mon_clr();
    wr(ADDR_CMD, {29'h0, m});
  endtask

  task automatic card_pulse;
    @(posedge ref_clk);
    card_trig <= 1'h1;
    @(posedge ref_clk);
    card_trig <= 1'h0;
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic t_regs;
    check("oe after reset", 32'h0, {29'h0, lines_oe});
    rchk("length", 8'h00 + 8'(OFS_LENGTH), RST_LENGTH);
    rchk("width", 8'h00 + 8'(OFS_WIDTH), RST_WIDTH);
    rchk("delay", 8'h00 + 8'(OFS_DELAY), RST_DELAY);
    rchk("loops", 8'h00 + 8'(OFS_LOOPS), RST_LOOPS);
    rchk("rate", ADDR_TICK_RATE, 32'(SAMPLE_HZ));
    wr(ADDR_TICK_SHIFT, 32'h3);
    wr(ADDR_TICK_RATE, 32'h5);
    rchk("shift", ADDR_TICK_SHIFT, 32'h3);
    rchk("rate div", ADDR_TICK_RATE, 32'(SAMPLE_HZ >> 3));
    rchk("unmapped", 8'h7C, 32'h0);
    wr(8'h40 + 8'(OFS_LENGTH), 32'hFFFF_FFFF);
    rchk("length full", 8'h40 + 8'(OFS_LENGTH), 32'hFFFF_FFFF);
    wr(ADDR_TICK_SHIFT, 32'h0);
  endtask

  task automatic t_single;
    setup(0, 32'h5, 32'h2, 32'h0, 32'h3,
          cw(MODE_SINGLE, SRC_SOFTWARE, GATE_NONE));
    setup(1, 32'h2, 32'h1, 32'h0, 32'h1,
          cw(MODE_REPEAT, SRC_GEN0, GATE_NONE));
    fire(3'h1);
    repeat (40) @(posedge ref_clk);
    check("pulses0", 32'h3, line_partner_inst.rises[0]);
    check("high0", 32'h2, line_partner_inst.hi_len[0]);
    check("low0", 32'h3, line_partner_inst.lo_len[0]);
    check("chained1", 32'h3, line_partner_inst.rises[1]);
    check("oe", 32'h3, {29'h0, lines_oe});
    rchk("status0", 8'(OFS_STATUS), 32'h4);
    fire(3'h1);
    repeat (40) @(posedge ref_clk);
    check("done refuses", 32'h0, line_partner_inst.rises[0]);
  endtask

  task automatic t_delay;
    setup(1, 32'h3, 32'h1, 32'h0, 32'h1,
          cw(MODE_SINGLE, SRC_SOFTWARE, GATE_NONE));
    fire(3'h2);
    repeat (30) @(posedge ref_clk);
    t0 = line_partner_inst.first_rise[1];
    setup(1, 32'h3, 32'h1, 32'h7, 32'h1,
          cw(MODE_SINGLE, SRC_SOFTWARE, GATE_NONE));
    fire(3'h2);
    rchk("active1", 8'h20 + 8'(OFS_STATUS), 32'h2);
    repeat (30) @(posedge ref_clk);
    check("delay", t0 + 32'h7, line_partner_inst.first_rise[1]);
  endtask

  task automatic t_card;
    setup(2, 32'h4, 32'h1, 32'h0, 32'h2,
          cw(MODE_REPEAT, SRC_CARD, GATE_RUNNING));
    mon_clr();
    card_pulse();
    check("gate closed", 32'h0, line_partner_inst.rises[2]);
    running_state <= 1'h1;
    card_pulse();
    card_pulse();
    check("repeat", 32'h4, line_partner_inst.rises[2]);
  endtask

  task automatic t_gated;
    logic [31:0] n;
    // Line 2 is an input only while its own generator is off
    wr(8'h40 + 8'(OFS_CTRL), 32'h0);
    setup(0, 32'h4, 32'h2, 32'h0, 32'h0,
          cw(MODE_GATED, SRC_LINE2, GATE_ARMED));
    mon_clr();
    drive <= 3'h4;
    repeat (20) @(posedge ref_clk);
    check("unarmed", 32'h0, line_partner_inst.rises[0]);
    drive <= 3'h0;
    armed_state <= 1'h1;
    repeat (5) @(posedge ref_clk);
    drive <= 3'h4;
    repeat (40) @(posedge ref_clk);
    drive <= 3'h0;
    repeat (10) @(posedge ref_clk);
    n = line_partner_inst.rises[0];
    check("endless", 32'h1, {31'h0, n >= 32'h8});
    repeat (20) @(posedge ref_clk);
    check("gate drop", n, line_partner_inst.rises[0]);
    check("line low", 32'h0, {31'h0, lines_out[0]});
  endtask

  task automatic t_shift;
    wr(ADDR_TICK_SHIFT, 32'h1);
    setup(1, 32'h3, 32'h2, 32'h0, 32'h1,
          cw(MODE_SINGLE, SRC_SOFTWARE, GATE_NONE));
    fire(3'h2);
    repeat (40) @(posedge ref_clk);
    check("slow high", 32'h4, line_partner_inst.hi_len[1]);
    wr(ADDR_TICK_SHIFT, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_regs();
    t_single();
    t_delay();
    t_card();
    t_gated();
    t_shift();
    print_verdict();
  end
endmodule
`default_nettype wire
